/* File: fsp_defines.svh */
// offsets, field positions, codes and timing of the protection block
`ifndef FSP_DEFINES_SVH
`define FSP_DEFINES_SVH
`define FSP_A_SR1      8'h00
`define FSP_A_CFG      8'h04
`define FSP_A_MODE     8'h08
`define FSP_A_SECT     8'h0c
`define FSP_A_CMD      8'h10
`define FSP_A_PWLO     8'h14
`define FSP_A_PWHI     8'h18
`define FSP_A_PSTAT    8'h1c
`define FSP_SR1_BUSY   0
`define FSP_SR1_WEL    1
`define FSP_SR1_BPLO   2
`define FSP_SR1_BPHI   4
`define FSP_SR1_PERR   6
`define FSP_SR1_STATUS_WRITE_DISABLE   7
`define FSP_CFG_FRZ    0
`define FSP_CFG_TB     5
`define FSP_MODE_LO    1
`define FSP_MODE_HI    2
`define FSP_MODE_NONE  2'b11
`define FSP_MODE_PERS  2'b10
`define FSP_MODE_PWD   2'b01
`define FSP_MODE_BAD   2'b00
`define FSP_OP_WRITE_ENABLE_CMD    8'h01
`define FSP_OP_WRREG   8'h02
`define FSP_OP_PPBP    8'h03
`define FSP_OP_PPBE    8'h04
`define FSP_OP_DYBW    8'h05
`define FSP_OP_LKCLR   8'h06
`define FSP_OP_PWUNL   8'h07
`define FSP_OP_PWPRG   8'h08
`define FSP_OP_MODEP   8'h09
`define FSP_OP_OTPP    8'h0a
`define FSP_OP_CLSR    8'h0b
`define FSP_OP_WRDI    8'h0c
`define FSP_NSECT      256
`define FSP_BP_UNIT    9'h004
`define FSP_PW_RST     64'hffff_ffff_ffff_ffff
`define FSP_CLK_MHZ    100
`define FSP_PROG_US    250
`define FSP_ERASE_US   500000
`define FSP_UNLOCK_US  100
`endif

/* File: fsp_pkg.sv */
// types shared by the protection block
package fsp_pkg;
  // register port request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } fsp_req_t;
  // sequencer states, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } fsp_state_t;
endpackage

/* File: fsp_protect.sv */
// sector protection, freeze lock and lock-mode logic of a serial flash
`timescale 1ns/100ps
`include "fsp_defines.svh"
module fsp_protect #(
  parameter int unsigned PROG_CYC   = `FSP_PROG_US * `FSP_CLK_MHZ,
  parameter int unsigned ERASE_CYC  = `FSP_ERASE_US * `FSP_CLK_MHZ,
  parameter int unsigned UNLOCK_CYC = `FSP_UNLOCK_US * `FSP_CLK_MHZ
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             hw_reset,
  input  wire logic             ce,
  input  wire logic             wp_n,
  input  wire fsp_pkg::fsp_req_t req,
  output logic [31:0]           rdata,
  input  wire logic [7:0]       pe_sector,
  output logic                  sector_protected,
  output logic                  otp_prog_lock,
  output logic                  busy
);
  import fsp_pkg::*;

  fsp_state_t               state_r;
  logic [31:0]              cnt_r;
  logic                     wel_r;
  logic                     perr_r;
  logic                     status_write_disable_r;
  logic [2:0]               bp_r;
  logic                     tb_r;
  logic                     freeze_r;
  logic [1:0]               mode_r;
  logic                     lock_r;
  logic [7:0]               sect_r;
  logic [63:0]              pw_r;
  logic [63:0]              pwin_r;
  logic [`FSP_NSECT-1:0]    ppb_r;
  logic [`FSP_NSECT-1:0]    dyb_r;
  logic [31:0]              rdata_r;
  logic [31:0]              rd_nxt;

  // block protect range test for one sector
  function automatic logic bp_hit(input logic [7:0] s, input logic [2:0] bp,
                                  input logic tb);
    logic [8:0] size;
    size = 9'h000;
    if (bp == 3'h7)
      size = 9'(`FSP_NSECT);
    else if (bp != 3'h0)
      size = 9'(`FSP_BP_UNIT << (bp - 3'h1));
    if (tb)
      bp_hit = {1'b0, s} < size;
    else
      bp_hit = {1'b0, s} >= (9'(`FSP_NSECT) - size);
  endfunction

  // command decode, accepted only while idle
  wire        idle     = (state_r == ST_IDLE);
  wire        cmd_go   = ce & req.wr & (req.addr == `FSP_A_CMD) & idle;
  wire [7:0]  op       = req.wdata[7:0];
  wire [23:0] arg      = req.wdata[31:8];
  wire        is_write_enable_cmd  = cmd_go & (op == `FSP_OP_WRITE_ENABLE_CMD);
  wire        is_wrdi  = cmd_go & (op == `FSP_OP_WRDI);
  wire        is_wrreg = cmd_go & (op == `FSP_OP_WRREG);
  wire        is_ppbp  = cmd_go & (op == `FSP_OP_PPBP);
  wire        is_ppbe  = cmd_go & (op == `FSP_OP_PPBE);
  wire        is_dybw  = cmd_go & (op == `FSP_OP_DYBW);
  wire        is_lkclr = cmd_go & (op == `FSP_OP_LKCLR);
  wire        is_pwunl = cmd_go & (op == `FSP_OP_PWUNL);
  wire        is_pwprg = cmd_go & (op == `FSP_OP_PWPRG);
  wire        is_modep = cmd_go & (op == `FSP_OP_MODEP);
  wire        is_otpp  = cmd_go & (op == `FSP_OP_OTPP);
  wire        is_clsr  = cmd_go & (op == `FSP_OP_CLSR);

  // mode and lock conditions
  wire       pwd_mode = (mode_r == `FSP_MODE_PWD);
  wire       mode_set = (mode_r != `FSP_MODE_NONE);
  wire [1:0] mode_arg = arg[`FSP_MODE_HI:`FSP_MODE_LO];
  wire       pw_match = (pwin_r == pw_r);
  wire       reg_lock = ~wp_n & status_write_disable_r;

  // outcome of each nonvolatile command
  wire wrreg_ok  = is_wrreg & wel_r & ~reg_lock;
  wire ppb_fail  = (is_ppbp | is_ppbe) & wel_r & ~lock_r;
  wire ppbp_ok   = is_ppbp & wel_r & lock_r;
  wire ppbe_ok   = is_ppbe & wel_r & lock_r;
  wire mode_fail = is_modep & wel_r & (mode_set | (mode_arg == `FSP_MODE_BAD));
  wire mode_ok   = is_modep & wel_r & ~mode_fail;
  wire otp_fail  = is_otpp & wel_r & freeze_r;
  wire otp_ok    = is_otpp & wel_r & ~freeze_r;
  wire pwprg_ok  = is_pwprg & wel_r & ~mode_set;
  wire unl_go    = is_pwunl & pwd_mode;
  wire unl_fail  = unl_go & ~pw_match;
  wire unl_ok    = unl_go & pw_match;
  wire fail_evt  = ppb_fail | mode_fail | otp_fail | unl_fail;
  wire nv_taken  = (is_ppbp | is_ppbe | is_modep | is_otpp | is_pwprg) & wel_r;

  // busy duration picked per command
  wire        start_busy = ppbp_ok | ppbe_ok | mode_ok | otp_ok | pwprg_ok | unl_go
                           | ppb_fail | mode_fail | otp_fail;
  wire [31:0] start_cnt  = ppbe_ok ? ERASE_CYC :
                           unl_fail ? UNLOCK_CYC :
                           (ppbp_ok | mode_ok | otp_ok | pwprg_ok) ? PROG_CYC :
                           32'h0000_0001;

  // busy sequencer
  always_ff @(posedge mclk)
  begin
    if (rst | hw_reset)
    begin
      state_r <= ST_IDLE;
      cnt_r   <= 32'h0000_0000;
    end
    else if (ce)
    begin
      case (state_r)
        ST_IDLE:
        begin
          if (start_busy)
          begin
            state_r <= ST_BUSY;
            cnt_r   <= start_cnt - 32'h0000_0001;
          end
        end
        ST_BUSY:
        begin
          if (cnt_r == 32'h0000_0000)
            state_r <= ST_IDLE;
          else
            cnt_r <= cnt_r - 32'h0000_0001;
        end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // write latch and program error flag
  always_ff @(posedge mclk)
  begin
    if (rst | hw_reset)
    begin
      wel_r  <= 1'b0;
      perr_r <= 1'b0;
    end
    else if (ce)
    begin
      if (is_write_enable_cmd)
        wel_r <= 1'b1;
      else if (is_wrdi | is_wrreg | nv_taken)
        wel_r <= 1'b0;
      if (fail_evt)
        perr_r <= 1'b1;
      else if (is_clsr)
        perr_r <= 1'b0;
    end
  end

  // status and configuration fields, freeze kept across hardware reset
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      freeze_r <= 1'b0;
      bp_r     <= 3'h0;
      tb_r     <= 1'b0;
      status_write_disable_r   <= 1'b0;
    end
    else if (ce & wrreg_ok)
    begin
      status_write_disable_r   <= arg[`FSP_SR1_STATUS_WRITE_DISABLE];
      freeze_r <= freeze_r | arg[8+`FSP_CFG_FRZ];
      if (!freeze_r)
      begin
        bp_r <= arg[`FSP_SR1_BPHI:`FSP_SR1_BPLO];
        tb_r <= arg[8+`FSP_CFG_TB];
      end
    end
  end

  // one-time mode field and hidden password
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      mode_r <= `FSP_MODE_NONE;
      pw_r   <= `FSP_PW_RST;
    end
    else if (ce)
    begin
      if (mode_ok)
        mode_r <= mode_r & mode_arg;
      if (pwprg_ok)
        pw_r <= pw_r & pwin_r;
    end
  end

  // persistent bit lock
  always_ff @(posedge mclk)
  begin
    if (rst)
      lock_r <= 1'b1;
    else if (hw_reset)
      lock_r <= ~pwd_mode;
    else if (ce)
    begin
      if (is_lkclr)
        lock_r <= 1'b0;
      else if (unl_ok)
        lock_r <= 1'b1;
    end
  end

  // per-sector persistent and dynamic bits
  always_ff @(posedge mclk)
  begin
    if (rst)
      ppb_r <= {`FSP_NSECT{1'b1}};
    else if (ce & ppbe_ok)
      ppb_r <= {`FSP_NSECT{1'b1}};
    else if (ce & ppbp_ok)
      ppb_r[sect_r] <= 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (rst | hw_reset)
      dyb_r <= {`FSP_NSECT{1'b1}};
    else if (ce & is_dybw)
      dyb_r[sect_r] <= arg[0];
  end

  // sector select and password entry registers
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      sect_r <= 8'h00;
      pwin_r <= 64'h0000_0000_0000_0000;
    end
    else if (ce & req.wr)
    begin
      if (req.addr == `FSP_A_SECT)
        sect_r <= req.wdata[7:0];
      else if (req.addr == `FSP_A_PWLO)
        pwin_r[31:0] <= req.wdata;
      else if (req.addr == `FSP_A_PWHI)
        pwin_r[63:32] <= req.wdata;
    end
  end

  // combined protection per sector
  wire pe_prot  = bp_hit(pe_sector, bp_r, tb_r) | ~ppb_r[pe_sector]
                  | ~dyb_r[pe_sector];
  wire sel_prot = bp_hit(sect_r, bp_r, tb_r) | ~ppb_r[sect_r] | ~dyb_r[sect_r];

  // status images
  wire [7:0] sr1_img  = {status_write_disable_r, perr_r, 1'b0, bp_r, wel_r, ~idle};
  wire [7:0] cfg_img  = {2'b00, tb_r, 4'h0, freeze_r};
  wire [7:0] mode_img = {5'h00, mode_r, 1'b0};
  wire [3:0] pst_img  = {sel_prot, dyb_r[sect_r], ppb_r[sect_r], lock_r};

  // read mux
  always_comb
  begin
    rd_nxt = 32'h0000_0000;
    if (req.addr == `FSP_A_SR1)
      rd_nxt = {24'h000000, sr1_img};
    else if (req.addr == `FSP_A_CFG)
      rd_nxt = {24'h000000, cfg_img};
    else if (req.addr == `FSP_A_MODE)
      rd_nxt = {24'h000000, mode_img};
    else if (req.addr == `FSP_A_SECT)
      rd_nxt = {24'h000000, sect_r};
    else if (req.addr == `FSP_A_PSTAT)
      rd_nxt = {28'h0000000, pst_img};
  end

  // read data stands only the cycle after the strobe
  always_ff @(posedge mclk)
  begin
    if (rst)
      rdata_r <= 32'h0000_0000;
    else if (ce)
      rdata_r <= req.rd ? rd_nxt : 32'h0000_0000;
  end

  assign rdata            = rdata_r;
  assign sector_protected = pe_prot;
  assign otp_prog_lock    = freeze_r;
  assign busy             = ~idle;

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_freeze_sticky;
    freeze_r |=> freeze_r;
  endproperty
  a_freeze_sticky: assert property (p_freeze_sticky)
    else $error("freeze flag dropped without power-on reset");

  property p_bp_frozen;
    freeze_r |=> $stable(bp_r) && $stable(tb_r);
  endproperty
  a_bp_frozen: assert property (p_bp_frozen)
    else $error("protect field changed under freeze");

  property p_otp_blocked;
    otp_fail |=> perr_r && busy;
  endproperty
  a_otp_blocked: assert property (p_otp_blocked)
    else $error("otp program not refused under freeze");

  property p_wp_refuse;
    is_wrreg && reg_lock |=> $stable(status_write_disable_r) && $stable(bp_r) && $stable(freeze_r);
  endproperty
  a_wp_refuse: assert property (p_wp_refuse)
    else $error("register write taken while pin protected");

  property p_sector_or;
    (!ppb_r[pe_sector] || !dyb_r[pe_sector] || bp_r == 3'h7) |-> sector_protected;
  endproperty
  a_sector_or: assert property (p_sector_or)
    else $error("protected sector reported open");

  property p_ppb_locked;
    ppb_fail |=> $stable(ppb_r) && perr_r;
  endproperty
  a_ppb_locked: assert property (p_ppb_locked)
    else $error("persistent bits changed while lock clear");

  property p_lock_stays;
    !lock_r && !pwd_mode && !hw_reset |=> !lock_r;
  endproperty
  a_lock_stays: assert property (p_lock_stays)
    else $error("lock rose in persistent mode");

  property p_pwd_reset;
    hw_reset && pwd_mode |=> !lock_r;
  endproperty
  a_pwd_reset: assert property (p_pwd_reset)
    else $error("hardware reset left lock set in password mode");

  property p_unlock_match;
    !lock_r ##1 lock_r && !$past(hw_reset) |-> $past(pw_match) && $past(pwd_mode);
  endproperty
  a_unlock_match: assert property (p_unlock_match)
    else $error("lock set without matching password");

  property p_mode_bad;
    mode_fail |=> perr_r && $stable(mode_r);
  endproperty
  a_mode_bad: assert property (p_mode_bad)
    else $error("illegal mode programming not failed");

  sequence s_busy_hold;
    busy [*8];
  endsequence
  property p_unlock_delay;
    unl_fail && ce |=> s_busy_hold;
  endproperty
  a_unlock_delay: assert property (p_unlock_delay)
    else $error("failed unlock did not hold busy");

  property p_mode_busy;
    mode_ok && ce |=> busy;
  endproperty
  a_mode_busy: assert property (p_mode_busy)
    else $error("mode programming not busy");
endmodule

/* File: fsp_host.sv */
// host model driving the register port of the protection block
`timescale 1ns/100ps
`include "fsp_defines.svh"
module fsp_host
(
  input  wire logic        mclk,
  output fsp_pkg::fsp_req_t req
);
  import fsp_pkg::*;
  initial req = '0;
  // one-cycle write, released at the taking edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    req <= {a, d, 1'b1, 1'b0};
    @(posedge mclk);
    req <= '0;
  endtask
  // one-cycle read strobe
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    req <= {a, 32'h0, 1'b0, 1'b1};
    @(posedge mclk);
    req <= '0;
  endtask
  // nonvolatile change always preceded by write enable
  task automatic nv(input logic [7:0] op, input logic [23:0] arg);
    wr(`FSP_A_CMD, {24'h0, `FSP_OP_WRITE_ENABLE_CMD});
    wr(`FSP_A_CMD, {arg, op});
  endtask
  // password entry, low word then high word
  task automatic pw_in(input logic [63:0] pw);
    wr(`FSP_A_PWLO, pw[31:0]);
    wr(`FSP_A_PWHI, pw[63:32]);
  endtask
  // password stored before any mode is chosen
  task automatic pw_set(input logic [63:0] pw);
    pw_in(pw);
    nv(`FSP_OP_PWPRG, 24'h0);
  endtask
endmodule

/* File: tb.sv */
// self-checking bench for the sector protection block
`timescale 1ns/100ps
`include "fsp_defines.svh"
module tb;
  import fsp_pkg::*;
  localparam int unsigned PC = 4;
  localparam int unsigned EC = 6;
  localparam int unsigned UC = 10;
  logic        mclk, rst, hw_reset, ce, wp_n, rd_pend;
  logic        sector_protected, otp_prog_lock, busy;
  logic [7:0]  pe_sector;
  logic [31:0] rdata;
  logic [63:0] pw;
  fsp_req_t    req;
  logic [31:0] exp_q[$];
  logic [7:0]  edge_s[8] = '{8'h00, 8'h03, 8'h04, 8'h7f, 8'h80, 8'hfb, 8'hfc, 8'hff};
  int          bad_count, total_checks, n;
  fsp_host host_i (.mclk(mclk), .req(req));
  fsp_protect #(.PROG_CYC(PC), .ERASE_CYC(EC), .UNLOCK_CYC(UC)) fsp_protect_i (
    .mclk(mclk), .rst(rst), .hw_reset(hw_reset), .ce(ce), .wp_n(wp_n), .req(req),
    .rdata(rdata), .pe_sector(pe_sector), .sector_protected(sector_protected),
    .otp_prog_lock(otp_prog_lock), .busy(busy));
  // clock
  initial mclk = 1'b0;
  always #5 mclk = ~mclk;
  // compare and count
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // read result stands only in the cycle after the strobe
  always @(posedge mclk)
  begin
    if (rd_pend === 1'b1)
      chk("rdata", rdata, exp_q.pop_front());
    rd_pend <= req.rd;
  end
  task automatic rx(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    host_i.rd(a);
  endtask
  task automatic cmd(input logic [7:0] op, input logic [23:0] arg);
    host_i.wr(`FSP_A_CMD, {arg, op});
  endtask
  // count busy cycles, bounded
  task automatic idle(output int cnt);
    cnt = 0;
    repeat (200)
    begin
      @(negedge mclk);
      if (busy !== 1'b1)
        break;
      cnt++;
    end
  endtask
  task automatic pulse(input bit hw);
    @(posedge mclk);
    if (hw)
      hw_reset <= 1'b1;
    else
      rst <= 1'b1;
    repeat (2) @(posedge mclk);
    hw_reset <= 1'b0;
    rst <= 1'b0;
  endtask
  function automatic logic bp_exp(int b, int t, int s);
    int k;
    k = (b == 7) ? 256 : ((b == 0) ? 0 : (4 << (b - 1)));
    return t ? (s < k) : (s >= 256 - k);
  endfunction
  task automatic sect_chk(input logic [7:0] s, input logic e);
    @(posedge mclk);
    pe_sector <= s;
    @(negedge mclk);
    chk("sector_protected", {31'h0, sector_protected}, {31'h0, e});
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // watchdog
  initial
  begin
    #(50000 * 10);
    bad_count++;
    wrap_up();
  end
  // main sequence
  initial
  begin
    rst = 1'b1; hw_reset = 1'b0; ce = 1'b1; wp_n = 1'b1;
    pe_sector = 8'h00; rd_pend = 1'b0; bad_count = 0; total_checks = 0;
    void'($urandom(40785));
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    rx(`FSP_A_SR1, 32'h0);
    rx(`FSP_A_MODE, 32'h6);
    rx(`FSP_A_PSTAT, 32'h7);
    cmd(`FSP_OP_WRITE_ENABLE_CMD, 24'h0);
    rx(`FSP_A_SR1, 32'h2);
    // write disable drops the latch; a register write without it changes nothing
    cmd(`FSP_OP_WRDI, 24'h0);
    rx(`FSP_A_SR1, 32'h0);
    cmd(`FSP_OP_WRREG, 24'h1c);
    rx(`FSP_A_SR1, 32'h0);
    // every protect field value at both anchors
    for (int b = 0; b < 8; b++)
      for (int t = 0; t < 2; t++)
      begin
        host_i.nv(`FSP_OP_WRREG, {8'h00, 8'(t << 5), 8'(b << 2)});
        for (int k = 0; k < 12; k++)
        begin
          n = (k < 8) ? edge_s[k] : $urandom_range(255);
          sect_chk(8'(n), bp_exp(b, t, n));
        end
      end
    // write protect pin with status_write_disable, then freeze
    host_i.nv(`FSP_OP_WRREG, 24'h80);
    @(posedge mclk);
    wp_n <= 1'b0;
    host_i.nv(`FSP_OP_WRREG, 24'h8c);
    rx(`FSP_A_SR1, 32'h80);
    @(posedge mclk);
    wp_n <= 1'b1;
    host_i.nv(`FSP_OP_WRREG, 24'h2108);
    rx(`FSP_A_CFG, 32'h21);
    host_i.nv(`FSP_OP_WRREG, 24'h0014);
    rx(`FSP_A_SR1, 32'h08);
    rx(`FSP_A_CFG, 32'h21);
    pulse(1);
    rx(`FSP_A_CFG, 32'h21);
    host_i.nv(`FSP_OP_OTPP, 24'h0);
    idle(n);
    rx(`FSP_A_SR1, 32'h48);
    chk("otp_prog_lock", {31'h0, otp_prog_lock}, 32'h1);
    cmd(`FSP_OP_CLSR, 24'h0);
    pulse(0);
    rx(`FSP_A_CFG, 32'h0);
    // per-sector bits and lock
    host_i.wr(`FSP_A_SECT, 32'h10);
    cmd(`FSP_OP_DYBW, 24'h0);
    rx(`FSP_A_PSTAT, 32'hb);
    sect_chk(8'h10, 1'b1);
    cmd(`FSP_OP_DYBW, 24'h1);
    host_i.nv(`FSP_OP_PPBP, 24'h0);
    idle(n);
    chk("ppb program busy", n, PC);
    rx(`FSP_A_PSTAT, 32'hd);
    cmd(`FSP_OP_LKCLR, 24'h0);
    cmd(`FSP_OP_PWUNL, 24'h0);
    rx(`FSP_A_PSTAT, 32'hc);
    host_i.nv(`FSP_OP_PPBE, 24'h0);
    idle(n);
    rx(`FSP_A_SR1, 32'h40);
    rx(`FSP_A_PSTAT, 32'hc);
    cmd(`FSP_OP_CLSR, 24'h0);
    pulse(1);
    rx(`FSP_A_PSTAT, 32'hd);
    host_i.nv(`FSP_OP_PPBE, 24'h0);
    idle(n);
    chk("ppb erase busy", n, EC);
    rx(`FSP_A_PSTAT, 32'h7);
    // clock enable low: a dynamic bit write is not taken
    @(posedge mclk);
    ce <= 1'b0;
    cmd(`FSP_OP_DYBW, 24'h0);
    ce <= 1'b1;
    rx(`FSP_A_PSTAT, 32'h7);
    // lock mode selection and password
    host_i.nv(`FSP_OP_MODEP, 24'h0);
    idle(n);
    rx(`FSP_A_SR1, 32'h40);
    rx(`FSP_A_MODE, 32'h6);
    cmd(`FSP_OP_CLSR, 24'h0);
    pw = {$urandom, $urandom};
    host_i.pw_set(pw);
    idle(n);
    host_i.nv(`FSP_OP_MODEP, 24'h2);
    idle(n);
    chk("mode program busy", n, PC);
    rx(`FSP_A_MODE, 32'h2);
    host_i.nv(`FSP_OP_MODEP, 24'h4);
    idle(n);
    rx(`FSP_A_MODE, 32'h2);
    cmd(`FSP_OP_CLSR, 24'h0);
    pulse(1);
    rx(`FSP_A_PSTAT, 32'h6);
    host_i.pw_in(pw ^ 64'h1);
    cmd(`FSP_OP_PWUNL, 24'h0);
    idle(n);
    chk("unlock busy", n, UC);
    rx(`FSP_A_SR1, 32'h40);
    rx(`FSP_A_PSTAT, 32'h6);
    cmd(`FSP_OP_CLSR, 24'h0);
    host_i.pw_in(pw);
    cmd(`FSP_OP_PWUNL, 24'h0);
    idle(n);
    rx(`FSP_A_PSTAT, 32'h7);
    cmd(`FSP_OP_LKCLR, 24'h0);
    rx(`FSP_A_PSTAT, 32'h6);
    repeat (3) @(posedge mclk);
    wrap_up();
  end
endmodule
